// ---- common/mpc_regs.vh ----
// constants for the modbus prefetch cache block
// assumes a 10 MHz system clock (100 ns period)
`ifndef MPC_REGS_VH
`define MPC_REGS_VH
`define MPC_CLK_HZ 32'd10000000
`define MPC_MAX_ADDR 8'd240
`define MPC_GRP_SMALL 8'd16
`define MPC_GRP_LARGE 8'd48
`define MPC_NODES 15
`define MPC_SYS_FIRST 16'd333
`define MPC_SYS_LAST 16'd348
`define MPC_LOAD_FIRST 16'd1501
`define MPC_LOAD_LAST 16'd1508
`define MPC_BLK_WORDS 8
`define MPC_REPORT_TMO_S 300
`define MPC_REPORT_TMO_CYC (`MPC_REPORT_TMO_S * `MPC_CLK_HZ)
`define MPC_MINUTE_S 60
`define MPC_MINUTE_CYC (`MPC_MINUTE_S * `MPC_CLK_HZ)
`define MPC_CACHE_REPLY_MS 10
`define MPC_CACHE_REPLY_CYC (`MPC_CACHE_REPLY_MS * (`MPC_CLK_HZ / 1000))
`endif

// ---- logic/mpc_prefetch_cache.v ----
// prefetch cache and radio sequencer of the modbus gateway
// assumes host requests and radio replies are single-cycle strobes in mclk_i domain
`include "mpc_regs.vh"
`default_nettype none
// Behaviour
// - report reads system block per enabled node, then load block per enabled load
// - report sequence aborts with timeout after five minutes total
// - when enabled, configured block is polled per interval into memory table
// - each cycle polls every enabled load, updating entries on fresh data
// - no response leaves cached entries unchanged, no zero, no exception
// - host read inside prefetch block answered from table, no radio access
// - other host requests stop polling and go over radio first
// - after preemption polling restarts from start at next minute boundary
// - polls without response retried once at end of same cycle
// - cached replies delivered well within ten milliseconds
// - overlong cycle starts next only at first interval boundary after completion
// - each node maps to 16 or 48 sequential slave addresses
// - global address space spans up to 240 addresses, gaps allowed
module mpc_prefetch_cache #(
  parameter [31:0] MINUTE_CYC = `MPC_MINUTE_CYC,
  parameter [31:0] REPORT_TMO_CYC = `MPC_REPORT_TMO_CYC
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // configuration
  input wire pf_enable_i,
  input wire [15:0] pf_first_reg_i,
  input wire [3:0] pf_interval_min_i,
  input wire group_large_i,
  input wire [14:0] node_enable_i,
  input wire [239:0] load_enable_i,
  input wire report_start_i,
  // host request
  input wire host_req_i,
  input wire [7:0] host_addr_i,
  input wire [15:0] host_reg_i,
  // cached answer and forward strobe to host
  output reg host_rsp_o,
  output reg [15:0] host_rsp_data_o,
  output reg host_fwd_o,
  // radio request and reply
  output reg radio_req_o,
  output reg [7:0] radio_addr_o,
  output reg [15:0] radio_reg_o,
  output reg [3:0] radio_cnt_o,
  output reg radio_fwd_o,
  input wire radio_ack_i,
  input wire radio_nak_i,
  input wire radio_wvalid_i,
  input wire [15:0] radio_wdata_i,
  // report status
  output reg report_busy_o,
  output reg report_done_o,
  output reg report_tmo_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_POLL = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_FWD = 3'd3;
  localparam ST_RPT = 3'd4;
  localparam ST_RWAIT = 3'd5;
  reg [15:0] table_mem [0:1919];
  reg [239:0] miss_reg;
  reg [2:0] state_reg;
  reg [7:0] slave_reg;
  reg [2:0] word_reg;
  reg retry_pass_reg;
  reg rpt_phase_reg;
  reg [31:0] min_cnt_reg;
  reg [3:0] min_tick_reg;
  reg start_pend_reg;
  reg preempt_reg;
  reg [31:0] tmo_cnt_reg;
  reg fwd_pend_reg;
  reg [7:0] fwd_addr_reg;
  reg [15:0] fwd_reg_reg;
  wire minute_edge;
  wire in_block;
  wire slave_on;
  wire [7:0] grp;
  wire [3:0] node_idx;
  wire [10:0] rd_idx;
  wire [10:0] wr_idx;
  wire [7:0] node_div;
  wire cache_hit;
  assign minute_edge = (min_cnt_reg == MINUTE_CYC - 32'd1);
  assign in_block = (host_reg_i >= pf_first_reg_i) && (host_reg_i < pf_first_reg_i + 16'd8);
  assign cache_hit = pf_enable_i && in_block && (host_addr_i < `MPC_MAX_ADDR);
  assign grp = group_large_i ? `MPC_GRP_LARGE : `MPC_GRP_SMALL;
  assign node_div = slave_reg / 8'd48;
  assign node_idx = group_large_i ? node_div[3:0] : slave_reg[7:4];
  assign slave_on = load_enable_i[slave_reg] && node_enable_i[node_idx];
  assign rd_idx = {host_addr_i, 3'd0} + {8'd0, host_reg_i[2:0] - pf_first_reg_i[2:0]};
  assign wr_idx = {slave_reg, word_reg};
  // table write on fresh data only, otherwise kept
  always @(posedge mclk_i) begin
    if (state_reg == ST_WAIT && radio_wvalid_i) begin
      table_mem[wr_idx] <= radio_wdata_i;
    end
  end
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      miss_reg <= 240'd0;
      slave_reg <= 8'h00;
      word_reg <= 3'h0;
      retry_pass_reg <= 1'b0;
      rpt_phase_reg <= 1'b0;
      min_cnt_reg <= 32'h0;
      min_tick_reg <= 4'h0;
      start_pend_reg <= 1'b0;
      preempt_reg <= 1'b0;
      tmo_cnt_reg <= 32'h0;
      fwd_pend_reg <= 1'b0;
      fwd_addr_reg <= 8'h00;
      fwd_reg_reg <= 16'h0000;
      host_rsp_o <= 1'b0;
      host_rsp_data_o <= 16'h0000;
      host_fwd_o <= 1'b0;
      radio_req_o <= 1'b0;
      radio_addr_o <= 8'h00;
      radio_reg_o <= 16'h0000;
      radio_cnt_o <= 4'h0;
      radio_fwd_o <= 1'b0;
      report_busy_o <= 1'b0;
      report_done_o <= 1'b0;
      report_tmo_o <= 1'b0;
    end else begin
      host_rsp_o <= 1'b0;
      host_fwd_o <= 1'b0;
      radio_req_o <= 1'b0;
      report_done_o <= 1'b0;
      min_cnt_reg <= minute_edge ? 32'h0 : min_cnt_reg + 32'd1;
      // cycles begin only on minute boundaries
      if (minute_edge) begin
        if (min_tick_reg + 4'd1 >= pf_interval_min_i || preempt_reg) begin
          min_tick_reg <= 4'h0;
          start_pend_reg <= pf_enable_i;
          preempt_reg <= 1'b0;
        end else begin
          min_tick_reg <= min_tick_reg + 4'd1;
        end
      end
      if (host_req_i && cache_hit) begin
        host_rsp_o <= 1'b1;
        host_rsp_data_o <= table_mem[rd_idx];
      end else if (host_req_i) begin
        fwd_pend_reg <= 1'b1;
        fwd_addr_reg <= host_addr_i;
        fwd_reg_reg <= host_reg_i;
        host_fwd_o <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (fwd_pend_reg) begin
            state_reg <= ST_FWD;
          end else if (report_start_i) begin
            state_reg <= ST_RPT;
            report_busy_o <= 1'b1;
            report_tmo_o <= 1'b0;
            tmo_cnt_reg <= 32'h0;
            rpt_phase_reg <= 1'b0;
            slave_reg <= 8'h00;
          end else if (start_pend_reg && pf_enable_i) begin
            start_pend_reg <= 1'b0;
            miss_reg <= 240'd0;
            state_reg <= ST_POLL;
            slave_reg <= 8'h00;
            retry_pass_reg <= 1'b0;
          end
        end
        ST_POLL: begin
          if (fwd_pend_reg) begin
            preempt_reg <= 1'b1;
            start_pend_reg <= 1'b0;
            state_reg <= ST_FWD;
          end else if (slave_reg >= `MPC_MAX_ADDR) begin
            if (!retry_pass_reg && |miss_reg) begin
              retry_pass_reg <= 1'b1;
              slave_reg <= 8'h00;
            end else begin
              miss_reg <= 240'd0;
              // boundaries seen while busy are dropped
              start_pend_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end else if (slave_on && (!retry_pass_reg || miss_reg[slave_reg])) begin
            radio_req_o <= 1'b1;
            radio_fwd_o <= 1'b0;
            radio_addr_o <= slave_reg + 8'd1;
            radio_reg_o <= pf_first_reg_i;
            radio_cnt_o <= 4'd8;
            word_reg <= 3'h0;
            state_reg <= ST_WAIT;
          end else begin
            slave_reg <= slave_reg + 8'd1;
          end
        end
        ST_WAIT: begin
          if (radio_wvalid_i) begin
            word_reg <= word_reg + 3'd1;
          end
          if (radio_ack_i || radio_nak_i) begin
            miss_reg[slave_reg] <= radio_nak_i && !retry_pass_reg;
            slave_reg <= slave_reg + 8'd1;
            state_reg <= ST_POLL;
          end
        end
        ST_FWD: begin
          radio_req_o <= 1'b1;
          radio_fwd_o <= 1'b1;
          radio_addr_o <= fwd_addr_reg + 8'd1;
          radio_reg_o <= fwd_reg_reg;
          radio_cnt_o <= 4'd1;
          // new outside request in this cycle stays pending
          fwd_pend_reg <= host_req_i && !cache_hit;
          state_reg <= ST_RWAIT;
        end
        ST_RPT: begin
          // system block per node, then load block per load
          if (slave_reg >= `MPC_MAX_ADDR) begin
            if (rpt_phase_reg) begin
              report_busy_o <= 1'b0;
              report_done_o <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              rpt_phase_reg <= 1'b1;
              slave_reg <= 8'h00;
            end
          end else if (rpt_phase_reg ? slave_on : node_enable_i[node_idx]) begin
            radio_req_o <= 1'b1;
            radio_fwd_o <= 1'b0;
            radio_addr_o <= slave_reg + 8'd1;
            radio_reg_o <= rpt_phase_reg ? `MPC_LOAD_FIRST : `MPC_SYS_FIRST;
            radio_cnt_o <= rpt_phase_reg ? 4'd8 : 4'd0;
            state_reg <= ST_RWAIT;
          end else begin
            slave_reg <= slave_reg + 8'd1;
          end
        end
        ST_RWAIT: begin
          if (radio_ack_i || radio_nak_i) begin
            if (radio_fwd_o) begin
              state_reg <= ST_IDLE;
            end else begin
              slave_reg <= rpt_phase_reg ? slave_reg + 8'd1 : slave_reg + grp;
              state_reg <= ST_RPT;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (report_busy_o) begin
        tmo_cnt_reg <= tmo_cnt_reg + 32'd1;
        if (tmo_cnt_reg >= REPORT_TMO_CYC - 32'd1) begin
          report_busy_o <= 1'b0;
          report_done_o <= 1'b0;
          report_tmo_o <= 1'b1;
          state_reg <= ST_IDLE;
        end
      end
    end
  end
endmodule // mpc_prefetch_cache
`default_nettype wire

// ---- testbench/mpc_prefetch_cache_assertions.sv ----
// port checker of the prefetch cache
// assumes the design ports keep their declared names
`default_nettype none
module mpc_chk (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pf_enable_i,
  input wire logic [15:0] pf_first_reg_i,
  input wire logic [239:0] load_enable_i,
  input wire logic host_req_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [15:0] host_reg_i,
  input wire logic host_rsp_o,
  input wire logic host_fwd_o,
  input wire logic radio_req_o,
  input wire logic [7:0] radio_addr_o,
  input wire logic [15:0] radio_reg_o,
  input wire logic [3:0] radio_cnt_o,
  input wire logic radio_fwd_o,
  input wire logic report_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire hit = pf_enable_i && host_addr_i < 8'hf0 && host_reg_i >= pf_first_reg_i && host_reg_i - pf_first_reg_i < 16'h8;
  wire poll = radio_req_o && !radio_fwd_o && !report_busy_o;
  a_cached_answer: assert property (host_req_i && hit |=> host_rsp_o && !host_fwd_o)
    else $error("cached read not answered");
  a_host_forward: assert property (host_req_i && !hit |=> host_fwd_o && !host_rsp_o)
    else $error("outside read not forwarded");
  a_fwd_sent: assert property (host_fwd_o |-> ##[1:300] (radio_req_o && radio_fwd_o))
    else $error("forward never sent");
  a_rsp_cause: assert property (host_rsp_o |-> $past(host_req_i))
    else $error("answer without request");
  a_poll_block: assert property (poll |-> radio_reg_o == pf_first_reg_i && radio_cnt_o == 4'h8)
    else $error("poll block wrong");
  a_poll_enabled: assert property (poll |-> load_enable_i[radio_addr_o - 8'h01])
    else $error("disabled slave polled");
  a_report_regs: assert property (radio_req_o && report_busy_o && !radio_fwd_o |->
    (radio_reg_o == 16'h014d && radio_cnt_o == 4'h0) || (radio_reg_o == 16'h05dd && radio_cnt_o == 4'h8))
    else $error("report read wrong");
  a_addr_space: assert property (radio_req_o && !radio_fwd_o |-> radio_addr_o inside {[8'h01:8'hf0]})
    else $error("slave address out of range");
endmodule // mpc_chk
bind mpc_prefetch_cache mpc_chk i_mpc_chk (.*);
`default_nettype wire

// ---- testbench/mpc_radio_model.sv ----
// far-side radio nodes answering cache requests
// assumes one-cycle request strobes on mclk_i
`default_nettype none
module mpc_radio_model (
  // request
  input wire logic mclk_i,
  input wire logic req_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] cnt_i,
  // test controls
  input wire logic [7:0] mute_addr_i,
  input wire logic [15:0] delay_i,
  // answer
  output logic ack_o,
  output logic nak_o,
  output logic wvalid_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] gen = 4'h0;
  initial begin
    ack_o = 1'b0;
    nak_o = 1'b0;
    wvalid_o = 1'b0;
    wdata_o = 16'h0000;
    forever begin
      @(posedge mclk_i);
      if (req_i) begin
        gen = gen + 4'h1;
        repeat (delay_i) @(posedge mclk_i);
        if (addr_i == mute_addr_i) begin
          nak_o <= 1'b1;
        end else begin
          for (int k = 0; k < (cnt_i == 4'h0 ? 16 : cnt_i); k++) begin
            wvalid_o <= 1'b1;
            wdata_o <= {gen, addr_i, k[3:0]};
            @(posedge mclk_i);
          end
          wvalid_o <= 1'b0;
          // stale data is not held
          wdata_o <= ~wdata_o;
          ack_o <= 1'b1;
        end
        @(posedge mclk_i);
        ack_o <= 1'b0;
        nak_o <= 1'b0;
      end
    end
  end
endmodule // mpc_radio_model
`default_nettype wire

// ---- testbench/test_modbus_prefetch_cache.sv ----
// self-checking bench of the prefetch cache
// assumes the radio model on the far side
`default_nettype none
`define MPC_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_modbus_prefetch_cache;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MIN = 200;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, pf_enable_i = 1'b0, host_req_i = 1'b0, report_start_i = 1'b0, ok;
  logic grp_large = 1'b0;
  logic [7:0] host_addr_i = 8'h00, mute = 8'h00, radio_addr_o;
  logic [15:0] host_reg_i = 16'h0000, dly = 16'h0001, rd, host_rsp_data_o, radio_reg_o, radio_wdata_i;
  logic host_rsp_o, host_fwd_o, radio_req_o, radio_fwd_o, report_busy_o, report_done_o, report_tmo_o;
  logic radio_ack_i, radio_nak_i, radio_wvalid_i;
  logic [3:0] radio_cnt_o, ivl = 4'h1;
  logic [7:0] sl [3] = '{8'h00, 8'h01, 8'h11};
  int n_fail = 0, samples_checked = 0, n_sys = 0, n_load = 0, n_late = 0, n_mute = 0, cyc = 0, s_sys = 0;
  always #50 mclk_i = ~mclk_i;
  mpc_prefetch_cache #(.MINUTE_CYC(32'd200), .REPORT_TMO_CYC(32'd5000)) i_mpc_prefetch_cache (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .pf_enable_i(pf_enable_i), .pf_first_reg_i(16'h0064), .pf_interval_min_i(ivl),
    .group_large_i(grp_large), .node_enable_i(15'h0003), .load_enable_i(240'h2_0003), .report_start_i(report_start_i),
    .host_req_i(host_req_i), .host_addr_i(host_addr_i), .host_reg_i(host_reg_i), .host_rsp_o(host_rsp_o),
    .host_rsp_data_o(host_rsp_data_o), .host_fwd_o(host_fwd_o), .radio_req_o(radio_req_o),
    .radio_addr_o(radio_addr_o), .radio_reg_o(radio_reg_o), .radio_cnt_o(radio_cnt_o), .radio_fwd_o(radio_fwd_o),
    .radio_ack_i(radio_ack_i), .radio_nak_i(radio_nak_i), .radio_wvalid_i(radio_wvalid_i),
    .radio_wdata_i(radio_wdata_i), .report_busy_o(report_busy_o), .report_done_o(report_done_o),
    .report_tmo_o(report_tmo_o));
  mpc_radio_model i_mpc_radio_model (.mclk_i(mclk_i), .req_i(radio_req_o), .addr_i(radio_addr_o),
    .cnt_i(radio_cnt_o), .mute_addr_i(mute), .delay_i(dly), .ack_o(radio_ack_i), .nak_o(radio_nak_i),
    .wvalid_o(radio_wvalid_i), .wdata_o(radio_wdata_i));
  always @(posedge mclk_i) begin
    if (rst_n_i) cyc++;
    if (radio_req_o && radio_reg_o == 16'h014d) s_sys += radio_addr_o;
    if (radio_req_o && radio_reg_o == 16'h014d && n_load > 0) n_late++;
    if (radio_req_o && radio_reg_o == 16'h014d) n_sys++;
    if (radio_req_o && radio_reg_o == 16'h05dd) n_load++;
    if (radio_req_o && radio_addr_o == 8'h02) n_mute++;
  end
  task automatic host_rd(input logic [7:0] a, input logic [15:0] r);
    @(posedge mclk_i);
    host_req_i <= 1'b1;
    host_addr_i <= a;
    host_reg_i <= r;
    @(posedge mclk_i);
    host_req_i <= 1'b0;
    #1 rd = host_rsp_data_o;
    ok = host_rsp_o;
  endtask
  task automatic wait_until(input logic [7:0] a, input logic fwd);
    int t = 0;
    do begin @(posedge mclk_i); #1; end
    while (!(radio_req_o && radio_fwd_o == fwd && (fwd || radio_addr_o == a)) && t++ < 400);
  endtask
  task automatic t_cache;
    pf_enable_i <= 1'b1;
    repeat (2 * MIN + 50) @(posedge mclk_i);
    foreach (sl[j]) for (int k = 0; k < 8; k += 7) begin
      host_rd(sl[j], 16'h0064 + 16'(k));
      `MPC_CHK(ok, 1'b1)
      `MPC_CHK(rd[11:0], {sl[j] + 8'h01, 4'(k)})
    end
  endtask
  task automatic t_mute;
    logic [15:0] old;
    mute = 8'h02;
    wait_until(8'h01, 1'b0);
    `MPC_CHK(cyc % MIN, 2)
    host_rd(8'h01, 16'h0065);
    old = rd;
    n_mute = 0;
    repeat (2 * MIN - 2) @(posedge mclk_i);
    `MPC_CHK(n_mute, 2)
    host_rd(8'h01, 16'h0065);
    `MPC_CHK(rd, old)
    mute = 8'h00;
  endtask
  task automatic t_fwd;
    host_rd(8'h03, 16'h0200);
    `MPC_CHK(host_fwd_o, 1'b1)
    wait_until(8'h00, 1'b1);
    `MPC_CHK({radio_addr_o, radio_reg_o}, {8'h04, 16'h0200})
    wait_until(8'h01, 1'b0);
    `MPC_CHK(cyc % MIN, 2)
  endtask
  task automatic t_report(input logic [15:0] d, input logic tmo, input logic g);
    int t = 0;
    pf_enable_i <= 1'b0;
    grp_large <= g;
    dly = d;
    repeat (600) @(posedge mclk_i);
    s_sys = 0;
    n_sys = 0;
    n_load = 0;
    n_late = 0;
    report_start_i <= 1'b1;
    @(posedge mclk_i);
    report_start_i <= 1'b0;
    while (!report_done_o && !report_tmo_o && t++ < 9000) begin @(posedge mclk_i); #1; end
    `MPC_CHK(report_tmo_o, tmo)
    if (!tmo) `MPC_CHK({n_sys, n_load, n_late}, {32'd2, 32'd3, 32'd0})
    if (!tmo) `MPC_CHK(s_sys, g ? 50 : 18)
  endtask
  task automatic complete_run;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_cache;
    t_mute;
    t_fwd;
    t_report(16'h0001, 1'b0, 1'b0);
    t_report(16'h0001, 1'b0, 1'b1);
    t_report(16'h05dc, 1'b1, 1'b0);
    complete_run;
  end
  initial begin
    #2000000;
    n_fail++;
    complete_run;
  end
endmodule // test_modbus_prefetch_cache
`default_nettype wire
